/* rtl/srd_storage_region_decoder.v */
/*
 * Storage region decoder: routes 15-bit word addresses to two core modules,
 * the fast control memory or the bootstrap read-only store.
 * Assumes processor/IO logic on SYS_CLK holds a request until ACK.
 */
// Overview of operation
// - Two 16K core modules give 32768 words and may cycle concurrently.
// - Core data passes a 30-bit buffer with separately used 15-bit halves.
// - Control memory holds 128 words, 400 ns cycle; BIG_CTL sizes it to 256 but only 128 are addressed.
// - 104 control words are dedicated, the other 24 hold general data.
// - Fetches, transfers and operands may all target control memory.
// - Bootstrap store holds 64 words, each read in 300 ns.
// - Two 32-word programs share one window; a switch picks one.
// - Bootstrap is entered and left by ordinary jumps and branches.
// - One 30-bit fast buffer carries control and bootstrap traffic.
// - Writes to bootstrap addresses leave its contents unchanged.
// - Low core holds fault and interrupt entrance addresses.
// - Control memory maps buffer control, clock and index words.
// - Reload and terminate storage sit at 00200 through 00257.
// - Core holds monitor, code, time-out and channel interrupt slots.
// - Each core module latches its 14-bit address per cycle.
// - An 8-bit register holds the fast memory address per cycle.
`include "srd_defs.vh"

module srd_storage_region_decoder #(
   parameter BIG_CTL  = 0,
   parameter CORE_CYC = `SRD_CORE_CYC,
   parameter CTL_CYC  = `SRD_CTL_CYC,
   parameter BOOT_CYC = `SRD_BOOT_CYC
) (
   input  wire                   SYS_CLK,
   input  wire                   NRST,
   input  wire                   BOOT_SEL_PIN,
   input  wire                   A_REQ,
   input  wire                   A_WRITE,
   input  wire [1:0]             A_HALF,
   input  wire [`SRD_ADDR_W-1:0] A_ADDR,
   input  wire [`SRD_WORD_W-1:0] A_WDATA,
   output wire                   A_ACK,
   output reg  [`SRD_WORD_W-1:0] A_RDATA,
   output reg  [3:0]             A_REGION,
   input  wire                   B_REQ,
   input  wire                   B_WRITE,
   input  wire [1:0]             B_HALF,
   input  wire [`SRD_ADDR_W-1:0] B_ADDR,
   input  wire [`SRD_WORD_W-1:0] B_WDATA,
   output wire                   B_ACK,
   output reg  [`SRD_WORD_W-1:0] B_RDATA,
   output reg  [3:0]             B_REGION
);
   localparam FW      = `SRD_FAST_AW;
   localparam CTL_N   = BIG_CTL ? `SRD_CTL_WORDS_BIG : `SRD_CTL_WORDS;
   localparam F_IDLE  = 2'h0;
   localparam F_CTL   = 2'h1;
   localparam F_BOOT  = 2'h2;

   // Port A uses the fast path and either core module first when both contend
   reg [`SRD_WORD_W-1:0] ctl_mem  [0:CTL_N-1];
   reg [`SRD_WORD_W-1:0] boot_rom [0:`SRD_BOOT_WORDS-1];

   reg                   sel_meta_ff;
   reg                   sel_ff;
   reg [1:0]             fstate_ff;
   reg [FW-1:0]          faddr_ff;
   reg [`SRD_WORD_W-1:0] fbuf_ff;
   reg                   fwrite_ff;
   reg                   fport_ff;
   reg [7:0]             fcnt_ff;
   reg                   fdone_ff;
   reg                   cport_ff [0:1];
   reg                   cwrite_ff [0:1];

   wire                   is_fast_a;
   wire                   is_fast_b;
   wire                   is_boot_a;
   wire                   is_boot_b;
   wire                   fast_go_a;
   wire                   fast_go_b;
   wire [1:0]             core_busy;
   wire [1:0]             core_done;
   wire [1:0]             core_start;
   wire [1:0]             core_port;
   wire [`SRD_WORD_W-1:0] core_rdata [0:1];

   function is_fast;
      input [`SRD_ADDR_W-1:0] a;
      begin
         is_fast = (a >= `SRD_CTL_LO && a <= `SRD_CTL_HI) ||
                   (a >= `SRD_BOOT_LO && a <= `SRD_BOOT_HI);
      end
   endfunction

   function [3:0] region;
      input [`SRD_ADDR_W-1:0] a;
      begin
         region = `SRD_RG_NONE;
         if (a == `SRD_FAULT_ENT)
            region = `SRD_RG_FAULT;
         else if (a >= `SRD_EXT_INT_LO && a <= `SRD_EXT_INT_HI)
            region = `SRD_RG_EXT_INT;
         else if (a >= `SRD_IN_MON_LO && a <= `SRD_IN_MON_HI)
            region = `SRD_RG_IN_MON;
         else if (a >= `SRD_OUT_MON_LO && a <= `SRD_OUT_MON_HI)
            region = `SRD_RG_OUT_MON;
         else if (a >= `SRD_IN_BCW_LO && a <= `SRD_IN_BCW_HI)
            region = `SRD_RG_IN_BCW;
         else if (a >= `SRD_OUT_BCW_LO && a <= `SRD_OUT_BCW_HI)
            region = `SRD_RG_OUT_BCW;
         else if (a >= `SRD_PCW_BCW_LO && a <= `SRD_PCW_BCW_HI)
            region = `SRD_RG_PCW_BCW;
         else if (a == `SRD_RTC)
            region = `SRD_RG_RTC;
         else if (a >= `SRD_IDX_LO && a <= `SRD_IDX_HI)
            region = `SRD_RG_IDX;
         else if (a >= `SRD_IN_RLD_LO && a <= `SRD_OUT_RLD_HI)
            region = `SRD_RG_RELOAD;
         else if (a >= `SRD_PCW_TRM_LO && a <= `SRD_PCW_TRM_HI)
            region = `SRD_RG_PCW_TRM;
         else if (a >= `SRD_FM_MON_LO && a <= `SRD_FM_MON_HI)
            region = `SRD_RG_FM_MON;
         else if (a >= `SRD_INT_CODE_LO && a <= `SRD_INT_CODE_HI)
            region = `SRD_RG_INT_CODE;
         else if (a >= `SRD_ICT_TO_LO && a <= `SRD_ICT_TO_HI)
            region = `SRD_RG_ICT_TO;
         else if (a >= `SRD_CHAN_INT_LO && a <= `SRD_CHAN_INT_HI)
            region = `SRD_RG_CHAN_INT;
      end
   endfunction

   // Control window 00100-00277 folds onto 128 words; top bit set is 0200+
   function [FW-1:0] fast_index;
      input [`SRD_ADDR_W-1:0] a;
      input                   boot_sel;
      begin
         if (a >= `SRD_BOOT_LO && a <= `SRD_BOOT_HI)
            fast_index = {2'h0, boot_sel, a[4:0]};
         else
            fast_index = a[FW-1:0] - 8'h40;
      end
   endfunction

   assign is_fast_a = is_fast(A_ADDR);
   assign is_fast_b = is_fast(B_ADDR);
   assign is_boot_a = (A_ADDR >= `SRD_BOOT_LO) && (A_ADDR <= `SRD_BOOT_HI);
   assign is_boot_b = (B_ADDR >= `SRD_BOOT_LO) && (B_ADDR <= `SRD_BOOT_HI);

   // any access may use fast path
   assign fast_go_a = A_REQ && is_fast_a && fstate_ff == F_IDLE && !fdone_ff;
   assign fast_go_b = B_REQ && is_fast_b && fstate_ff == F_IDLE && !fdone_ff && !fast_go_a;

   // Boot switch is a panel pin: two-stage synchroniser
   always @(posedge SYS_CLK) begin
      if (!NRST) begin
         sel_meta_ff <= 1'b0;
         sel_ff      <= 1'b0;
      end else begin
         sel_meta_ff <= BOOT_SEL_PIN;
         sel_ff      <= sel_meta_ff;
      end
   end

   // Fast memory cycle engine
   always @(posedge SYS_CLK) begin
      if (!NRST) begin
         fstate_ff <= F_IDLE;
         faddr_ff  <= {FW{1'b0}};
         fbuf_ff   <= {`SRD_WORD_W{1'b0}};
         fwrite_ff <= 1'b0;
         fport_ff  <= 1'b0;
         fcnt_ff   <= 8'h00;
         fdone_ff  <= 1'b0;
      end else begin
         fdone_ff <= 1'b0;
         case (fstate_ff)
            F_IDLE: begin
               if (fast_go_a || fast_go_b) begin
                  faddr_ff  <= fast_index(fast_go_a ? A_ADDR : B_ADDR, sel_ff);
                  fwrite_ff <= fast_go_a ? A_WRITE : B_WRITE;
                  fport_ff  <= fast_go_b;
                  fbuf_ff   <= fast_go_a ? A_WDATA : B_WDATA;
                  fcnt_ff   <= (fast_go_a ? is_boot_a : is_boot_b) ?
                               BOOT_CYC[7:0] : CTL_CYC[7:0];
                  fstate_ff <= (fast_go_a ? is_boot_a : is_boot_b) ? F_BOOT : F_CTL;
               end
            end
            F_CTL: begin
               fcnt_ff <= fcnt_ff - 8'h01;
               if (fcnt_ff == 8'h01) begin
                  if (!fwrite_ff)
                     fbuf_ff <= ctl_mem[faddr_ff[6:0]];
                  fdone_ff  <= 1'b1;
                  fstate_ff <= F_IDLE;
               end
            end
            F_BOOT: begin
               fcnt_ff <= fcnt_ff - 8'h01;
               if (fcnt_ff == 8'h01) begin
                  if (!fwrite_ff)
                     fbuf_ff <= boot_rom[faddr_ff[5:0]];
                  fdone_ff  <= 1'b1;
                  fstate_ff <= F_IDLE;
               end
            end
            default: fstate_ff <= F_IDLE;
         endcase
      end
   end

   always @(posedge SYS_CLK) begin
      if (NRST && fstate_ff == F_CTL && fcnt_ff == 8'h01 && fwrite_ff)
         ctl_mem[faddr_ff[6:0]] <= fbuf_ff;
   end

   // Program contents are site data; loader image not part of this block
   integer k;
   initial begin
      for (k = 0; k < `SRD_BOOT_WORDS; k = k + 1)
         boot_rom[k] = {`SRD_WORD_W{1'b0}};
   end

   genvar m;
   generate
      for (m = 0; m < 2; m = m + 1) begin : g_core
         wire a_hit = A_REQ && !is_fast_a && (A_ADDR[`SRD_ADDR_W-1] == m);
         wire b_hit = B_REQ && !is_fast_b && (B_ADDR[`SRD_ADDR_W-1] == m);
         assign core_start[m] = !core_busy[m] && !core_done[m] && (a_hit || b_hit);
         assign core_port[m]  = !a_hit;

         always @(posedge SYS_CLK) begin
            if (!NRST) begin
               cport_ff[m]  <= 1'b0;
               cwrite_ff[m] <= 1'b0;
            end else if (core_start[m]) begin
               cport_ff[m]  <= core_port[m];
               cwrite_ff[m] <= core_port[m] ? B_WRITE : A_WRITE;
            end
         end

         srd_core_module #(
            .CYC (CORE_CYC)
         ) u_core (
            .clk     (SYS_CLK),
            .nrst    (NRST),
            .start   (core_start[m]),
            .write   (core_port[m] ? B_WRITE : A_WRITE),
            .half_en (core_port[m] ? B_HALF : A_HALF),
            .addr    (core_port[m] ? B_ADDR[`SRD_CORE_AW-1:0] : A_ADDR[`SRD_CORE_AW-1:0]),
            .wdata   (core_port[m] ? B_WDATA : A_WDATA),
            .busy    (core_busy[m]),
            .done_ff (core_done[m]),
            .rdata   (core_rdata[m])
         );
      end
   endgenerate

   assign A_ACK = (fdone_ff && !fport_ff) ||
                  (core_done[0] && !cport_ff[0]) || (core_done[1] && !cport_ff[1]);
   assign B_ACK = (fdone_ff && fport_ff) ||
                  (core_done[0] && cport_ff[0]) || (core_done[1] && cport_ff[1]);

   always @(posedge SYS_CLK) begin
      if (!NRST) begin
         A_RDATA  <= {`SRD_WORD_W{1'b0}};
         B_RDATA  <= {`SRD_WORD_W{1'b0}};
         A_REGION <= `SRD_RG_NONE;
         B_REGION <= `SRD_RG_NONE;
      end else begin
         A_REGION <= region(A_ADDR);
         B_REGION <= region(B_ADDR);
         if (fstate_ff != F_IDLE && fcnt_ff == 8'h01 && !fwrite_ff) begin
            if (!fport_ff)
               A_RDATA <= (fstate_ff == F_BOOT) ? boot_rom[faddr_ff[5:0]]
                                               : ctl_mem[faddr_ff[6:0]];
            else
               B_RDATA <= (fstate_ff == F_BOOT) ? boot_rom[faddr_ff[5:0]]
                                               : ctl_mem[faddr_ff[6:0]];
         end
         // core reads leave through the module half buffers
         if (core_done[0] && !cwrite_ff[0] && !cport_ff[0])
            A_RDATA <= core_rdata[0];
         if (core_done[0] && !cwrite_ff[0] && cport_ff[0])
            B_RDATA <= core_rdata[0];
         if (core_done[1] && !cwrite_ff[1] && !cport_ff[1])
            A_RDATA <= core_rdata[1];
         if (core_done[1] && !cwrite_ff[1] && cport_ff[1])
            B_RDATA <= core_rdata[1];
      end
   end
endmodule

/* rtl/srd_defs.vh */
/*
 * Storage region decoder constants: address windows, widths and cycle timing.
 * Assumes a 25 MHz machine clock; addresses are 15-bit octal word addresses.
 */
`ifndef SRD_DEFS_VH
`define SRD_DEFS_VH

`define SRD_ADDR_W        15
`define SRD_WORD_W        30
`define SRD_HALF_W        15
`define SRD_CORE_AW       14
`define SRD_FAST_AW       8
`define SRD_CTL_WORDS     128
`define SRD_CTL_WORDS_BIG 256
`define SRD_BOOT_WORDS    64
`define SRD_BOOT_PROG     32
`define SRD_CTL_DEDICATED 104
`define SRD_CTL_GENERAL   24

`define SRD_CTL_LO        15'o00100
`define SRD_CTL_HI        15'o00277
`define SRD_BOOT_LO       15'o00540
`define SRD_BOOT_HI       15'o00577

`define SRD_FAULT_ENT     15'o00000
`define SRD_EXT_INT_LO    15'o00020
`define SRD_EXT_INT_HI    15'o00037
`define SRD_IN_MON_LO     15'o00040
`define SRD_IN_MON_HI     15'o00057
`define SRD_OUT_MON_LO    15'o00060
`define SRD_OUT_MON_HI    15'o00077
`define SRD_IN_BCW_LO     15'o00100
`define SRD_IN_BCW_HI     15'o00117
`define SRD_OUT_BCW_LO    15'o00120
`define SRD_OUT_BCW_HI    15'o00137
`define SRD_PCW_BCW_LO    15'o00140
`define SRD_PCW_BCW_HI    15'o00157
`define SRD_RTC           15'o00160
`define SRD_IDX_LO        15'o00161
`define SRD_IDX_HI        15'o00167
`define SRD_IN_RLD_LO     15'o00200
`define SRD_IN_RLD_HI     15'o00217
`define SRD_OUT_RLD_LO    15'o00220
`define SRD_OUT_RLD_HI    15'o00237
`define SRD_PCW_TRM_LO    15'o00240
`define SRD_PCW_TRM_HI    15'o00257
`define SRD_FM_MON_LO     15'o00500
`define SRD_FM_MON_HI     15'o00517
`define SRD_INT_CODE_LO   15'o00520
`define SRD_INT_CODE_HI   15'o00537
`define SRD_ICT_TO_LO     15'o00600
`define SRD_ICT_TO_HI     15'o00617
`define SRD_CHAN_INT_LO   15'o00620
`define SRD_CHAN_INT_HI   15'o00653

`define SRD_CLK_MHZ       25
`define SRD_CORE_CYC_NS   2000
`define SRD_CTL_CYC_NS    400
`define SRD_BOOT_CYC_NS   300
`define SRD_CORE_CYC      ((`SRD_CORE_CYC_NS * `SRD_CLK_MHZ + 999) / 1000)
`define SRD_CTL_CYC       ((`SRD_CTL_CYC_NS * `SRD_CLK_MHZ + 999) / 1000)
`define SRD_BOOT_CYC      ((`SRD_BOOT_CYC_NS * `SRD_CLK_MHZ + 999) / 1000)

`define SRD_RG_NONE       4'h0
`define SRD_RG_FAULT      4'h1
`define SRD_RG_EXT_INT    4'h2
`define SRD_RG_IN_MON     4'h3
`define SRD_RG_OUT_MON    4'h4
`define SRD_RG_IN_BCW     4'h5
`define SRD_RG_OUT_BCW    4'h6
`define SRD_RG_PCW_BCW    4'h7
`define SRD_RG_RTC        4'h8
`define SRD_RG_IDX        4'h9
`define SRD_RG_RELOAD     4'hA
`define SRD_RG_PCW_TRM    4'hB
`define SRD_RG_FM_MON     4'hC
`define SRD_RG_INT_CODE   4'hD
`define SRD_RG_ICT_TO     4'hE
`define SRD_RG_CHAN_INT   4'hF

`endif

/* rtl/srd_core_module.v */
/*
 * One 16K-word core module: address register, half-word buffer and a
 * fixed-length read/restore cycle.
 * Assumes the decoder starts a cycle only while busy is low.
 */
`include "srd_defs.vh"

module srd_core_module #(
   parameter AW    = `SRD_CORE_AW,
   parameter DW    = `SRD_WORD_W,
   parameter HW    = `SRD_HALF_W,
   parameter CYC   = `SRD_CORE_CYC
) (
   input  wire          clk,
   input  wire          nrst,
   input  wire          start,
   input  wire          write,
   input  wire [1:0]    half_en,
   input  wire [AW-1:0] addr,
   input  wire [DW-1:0] wdata,
   output wire          busy,
   output reg           done_ff,
   output wire [DW-1:0] rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];
   reg [AW-1:0] addr_ff;
   reg [HW-1:0] buf_upper_ff;
   reg [HW-1:0] buf_lower_ff;
   reg [1:0]    half_ff;
   reg          write_ff;
   reg [7:0]    cnt_ff;

   assign busy  = (cnt_ff != 8'h00);
   assign rdata = {buf_upper_ff, buf_lower_ff};

   always @(posedge clk) begin
      if (!nrst) begin
         addr_ff      <= {AW{1'b0}};
         buf_upper_ff <= {HW{1'b0}};
         buf_lower_ff <= {HW{1'b0}};
         half_ff      <= 2'h0;
         write_ff     <= 1'b0;
         cnt_ff       <= 8'h00;
         done_ff      <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (start && !busy) begin
            addr_ff  <= addr;
            write_ff <= write;
            half_ff  <= half_en;
            cnt_ff   <= CYC[7:0];
            if (write && half_en[1])
               buf_upper_ff <= wdata[DW-1:HW];
            if (write && half_en[0])
               buf_lower_ff <= wdata[HW-1:0];
         end else if (busy) begin
            cnt_ff <= cnt_ff - 8'h01;
            if (cnt_ff == CYC[7:0] && !write_ff) begin
               buf_upper_ff <= mem[addr_ff][DW-1:HW];
               buf_lower_ff <= mem[addr_ff][HW-1:0];
            end
            if (cnt_ff == 8'h01)
               done_ff <= 1'b1;
         end
      end
   end

   // Restore phase writes whole word; unselected half keeps old contents
   always @(posedge clk) begin
      if (nrst && busy && write_ff && cnt_ff == 8'h01)
         mem[addr_ff] <= {half_ff[1] ? buf_upper_ff : mem[addr_ff][DW-1:HW],
                          half_ff[0] ? buf_lower_ff : mem[addr_ff][HW-1:0]};
   end
endmodule

/* verification/srd_region_chk.sv */
/*
 * Checker on the ports of the storage region decoder.
 * Assumes one clock, a synchronous active-low reset and requests held until ACK.
 */
`include "srd_defs.vh"

module srd_region_chk #(
   parameter int CTL_CYC  = 10,
   parameter int BOOT_CYC = 8,
   parameter int CORE_CYC = 50
) (
   input wire        SYS_CLK,
   input wire        NRST,
   input wire        A_REQ,
   input wire        A_WRITE,
   input wire [14:0] A_ADDR,
   input wire        A_ACK,
   input wire [29:0] A_RDATA,
   input wire [3:0]  A_REGION,
   input wire        B_REQ,
   input wire [14:0] B_ADDR,
   input wire        B_ACK
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CORE_L = CORE_CYC + 1;
   localparam int MAXW   = 2 * CORE_L + 4;
   logic [7:0] a_cnt_ff;
   logic [7:0] b_cnt_ff;
   logic       a_clean_ff;

   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);

   function automatic int lat_of(input logic [14:0] a);
      if (a >= `SRD_CTL_LO && a <= `SRD_CTL_HI) return CTL_CYC + 1;
      if (a >= `SRD_BOOT_LO && a <= `SRD_BOOT_HI) return BOOT_CYC + 1;
      return CORE_CYC + 1;
   endfunction

   // Exact latency only when B cannot hold the target ahead of A
   always @(posedge SYS_CLK) begin
      a_cnt_ff <= (!NRST || !A_REQ) ? 8'h00 : a_cnt_ff + 8'h01;
      b_cnt_ff <= (!NRST || !B_REQ) ? 8'h00 : b_cnt_ff + 8'h01;
      if (A_REQ && a_cnt_ff == 8'h00)
         a_clean_ff <= !B_REQ || b_cnt_ff == 8'h00;
   end

   sequence boot_rd;
      A_ACK && !A_WRITE && A_ADDR >= `SRD_BOOT_LO && A_ADDR <= `SRD_BOOT_HI;
   endsequence

   sequence both_core;
      $rose(A_REQ) && $rose(B_REQ) && lat_of(A_ADDR) == CORE_L && lat_of(B_ADDR) == CORE_L;
   endsequence

   ack_a_pulse_a: assert property (A_ACK |=> !A_ACK)
      else $error("port A acknowledge longer than one cycle");
   ack_b_pulse_a: assert property (B_ACK |=> !B_ACK)
      else $error("port B acknowledge longer than one cycle");
   ack_has_req_a: assert property ((A_ACK -> A_REQ) && (B_ACK -> B_REQ))
      else $error("acknowledge without a pending request");
   a_latency_a: assert property (A_ACK && a_clean_ff |-> int'(a_cnt_ff) == lat_of(A_ADDR))
      else $error("port A cycle length wrong for its region");
   b_latency_a: assert property (B_ACK |-> int'(b_cnt_ff) >= lat_of(B_ADDR))
      else $error("port B answered before its cycle ended");
   ack_bound_a: assert property ($rose(A_REQ) |-> ##[1:MAXW] A_ACK)
      else $error("port A request never answered");
   boot_zero_a: assert property (boot_rd |-> ##2 A_RDATA == 30'h0)
      else $error("bootstrap read returned altered contents");
   dual_core_a: assert property (both_core ##0 A_ADDR[14] != B_ADDR[14] |-> ##CORE_L (A_ACK && B_ACK))
      else $error("two core modules did not cycle together");
   same_core_a: assert property (both_core ##0 A_ADDR[14] == B_ADDR[14] |-> ##CORE_L (A_ACK && !B_ACK))
      else $error("one core module served two requests at once");
   rtc_region_a: assert property (A_ACK && A_ADDR == `SRD_RTC |=> A_REGION == `SRD_RG_RTC)
      else $error("clock word not reported in its region");
endmodule

/* verification/srd_req_model.sv */
/*
 * Requester model of the processor and transfer logic on one decoder port.
 * Assumes the bench raises go to start one transfer and lowers it afterwards.
 */
module srd_req_model (
   input  wire         clk,
   input  wire         go,
   input  wire         wr,
   input  wire  [1:0]  half,
   input  wire  [14:0] addr,
   input  wire  [29:0] wdata,
   input  wire  [3:0]  dly,
   input  wire         ack,
   output logic        req,
   output logic        write,
   output logic [1:0]  half_o,
   output logic [14:0] addr_o,
   output logic [29:0] wdata_o,
   output logic        busy,
   output int          lat
);
   timeunit 1ns;
   timeprecision 1ps;
   logic go_prev;

   initial begin
      {req, write, busy, go_prev} = 4'h0;
      {half_o, addr_o, wdata_o} = '1;
      lat = 0;
      forever begin
         @(negedge clk);
         if (go && !go_prev) begin
            busy = 1'b1;
            // Slow requester: idle a few cycles before asking
            repeat (dly) @(negedge clk);
            {req, write, half_o, addr_o, wdata_o} = {1'b1, wr, half, addr, wdata};
            lat = -1;
            do begin
               @(posedge clk);
               lat++;
            end while (ack !== 1'b1);
            @(negedge clk);
            // Released lines show the inverse, never a stale copy
            {req, write, half_o, addr_o, wdata_o} = {1'b0, ~write, ~half_o, ~addr_o, ~wdata_o};
            busy = 1'b0;
         end
         go_prev = go;
      end
   end
endmodule

/* verification/srd_storage_region_decoder_test.sv */
/*
 * Self-checking bench for the storage region decoder, two requester models.
 * Assumes ACK is a one-cycle pulse; fast read data lands with it, core read data one cycle after it.
 */
`include "srd_defs.vh"

module srd_storage_region_decoder_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CTL  = 3;
   localparam int BOOT = 2;
   localparam int CORE = 6;
   localparam logic [14:0] LO [15] = '{`SRD_FAULT_ENT, `SRD_EXT_INT_LO, `SRD_IN_MON_LO,
      `SRD_OUT_MON_LO, `SRD_IN_BCW_LO, `SRD_OUT_BCW_LO, `SRD_PCW_BCW_LO, `SRD_RTC,
      `SRD_IDX_LO, `SRD_IN_RLD_LO, `SRD_PCW_TRM_LO, `SRD_FM_MON_LO, `SRD_INT_CODE_LO,
      `SRD_ICT_TO_LO, `SRD_CHAN_INT_LO};
   localparam logic [14:0] HI [15] = '{`SRD_FAULT_ENT, `SRD_EXT_INT_HI, `SRD_IN_MON_HI,
      `SRD_OUT_MON_HI, `SRD_IN_BCW_HI, `SRD_OUT_BCW_HI, `SRD_PCW_BCW_HI, `SRD_RTC,
      `SRD_IDX_HI, `SRD_OUT_RLD_HI, `SRD_PCW_TRM_HI, `SRD_FM_MON_HI, `SRD_INT_CODE_HI,
      `SRD_ICT_TO_HI, `SRD_CHAN_INT_HI};
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        sel = 1'b0;
   logic        go [2] = '{default: 1'b0};
   logic        wr [2] = '{default: 1'b0};
   logic [1:0]  half [2] = '{default: 2'h0};
   logic [14:0] ad [2] = '{default: 15'h0};
   logic [29:0] wd [2] = '{default: 30'h0};
   logic [3:0]  dly [2] = '{default: 4'h0};
   wire         req [2];
   wire         mw [2];
   wire  [1:0]  mh [2];
   wire  [14:0] ma [2];
   wire  [29:0] md [2];
   wire         ack [2];
   wire         busy [2];
   wire  [29:0] rd [2];
   wire  [3:0]  rg [2];
   int          lat [2];
   logic [3:0]  rg_ack [2];
   int          error_cnt = 0;
   int          n_checks = 0;
   int          seed = 32'h931C;

   always #20 sys_clk = ~sys_clk;

   // Region follows the address; take it at the acknowledge, before release
   always @(posedge sys_clk)
      for (int p = 0; p < 2; p++)
         if (ack[p] === 1'b1)
            rg_ack[p] <= rg[p];

   for (genvar p = 0; p < 2; p++) begin : g_port
      srd_req_model u_m (.clk(sys_clk), .go(go[p]), .wr(wr[p]), .half(half[p]), .addr(ad[p]),
         .wdata(wd[p]), .dly(dly[p]), .ack(ack[p]), .req(req[p]), .write(mw[p]),
         .half_o(mh[p]), .addr_o(ma[p]), .wdata_o(md[p]), .busy(busy[p]), .lat(lat[p]));
   end

   srd_storage_region_decoder #(.BIG_CTL(0), .CORE_CYC(CORE), .CTL_CYC(CTL), .BOOT_CYC(BOOT))
   uut (.SYS_CLK(sys_clk), .NRST(nrst), .BOOT_SEL_PIN(sel),
      .A_REQ(req[0]), .A_WRITE(mw[0]), .A_HALF(mh[0]), .A_ADDR(ma[0]), .A_WDATA(md[0]),
      .A_ACK(ack[0]), .A_RDATA(rd[0]), .A_REGION(rg[0]),
      .B_REQ(req[1]), .B_WRITE(mw[1]), .B_HALF(mh[1]), .B_ADDR(ma[1]), .B_WDATA(md[1]),
      .B_ACK(ack[1]), .B_RDATA(rd[1]), .B_REGION(rg[1]));

   function automatic logic [3:0] rg_exp(input logic [14:0] a);
      for (int i = 0; i < 15; i++)
         if (a >= LO[i] && a <= HI[i]) return 4'(i + 1);
      return `SRD_RG_NONE;
   endfunction

   function automatic int lat_exp(input logic [14:0] a);
      if (a >= `SRD_CTL_LO && a <= `SRD_CTL_HI) return CTL + 1;
      if (a >= `SRD_BOOT_LO && a <= `SRD_BOOT_HI) return BOOT + 1;
      return CORE + 1;
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic post(input int p, input logic w, input logic [14:0] a,
                       input logic [29:0] d, input logic [3:0] dl);
      wr[p] <= w;
      ad[p] <= a;
      wd[p] <= d;
      half[p] <= 2'($random(seed));
      dly[p] <= dl;
      go[p] <= 1'b1;
   endtask

   task automatic finish(input int p, output int l);
      repeat (2) @(posedge sys_clk);
      for (int i = 0; i < 300 && busy[p]; i++) @(posedge sys_clk);
      chk("done", busy[p], 0);
      @(negedge sys_clk);
      go[p] <= 1'b0;
      l = lat[p];
   endtask

   task automatic op(input int p, input logic w, input logic [14:0] a, input logic [29:0] d);
      int l;
      @(negedge sys_clk);
      post(p, w, a, d, 4'($random(seed) & 3));
      finish(p, l);
      chk("latency", l, lat_exp(a));
      chk("region", rg_ack[p], rg_exp(a));
   endtask

   initial begin
      logic [29:0] mem [logic [14:0]];
      logic [14:0] a;
      logic [14:0] b;
      int          l;
      int          l2;
      logic [29:0] d;
      logic [29:0] msk;
      repeat (5) @(negedge sys_clk);
      chk("ack_rst", {ack[0], ack[1]}, 0);
      chk("rdata_rst", rd[0], 0);
      chk("region_rst", rg[1], 0);
      @(negedge sys_clk);
      nrst = 1'b1;
      repeat (3) @(negedge sys_clk);
      // Scattered fast writes first, so aliasing words would show on readback
      for (int i = 0; i < 24; i++) begin
         a = i == 0 ? `SRD_CTL_LO : i == 1 ? `SRD_CTL_HI : `SRD_CTL_LO + 15'($random(seed) & 127);
         mem[a] = 30'($random(seed));
         op(i % 2, 1'b1, a, mem[a]);
      end
      foreach (mem[k]) begin
         op(k[0], 1'b0, k, 30'h0);
         chk("ctl_rdata", rd[k[0]], mem[k]);
      end
      for (int i = 0; i < 30; i++)
         op(i % 2, i[2], i < 15 ? LO[i] : HI[i - 15], 30'($random(seed)));
      for (int s = 0; s < 2; s++) begin
         sel = s[0];
         repeat (3) @(negedge sys_clk);
         for (int i = 0; i < 6; i++) begin
            a = `SRD_BOOT_LO + 15'(i * 6 + i / 5);
            op(i % 2, 1'b1, a, 30'($random(seed)));
            op(s, 1'b0, a, 30'h0);
            chk("boot_rdata", rd[s], 30'h0);
         end
      end
      for (int i = 0; i < 20; i++)
         op(i % 2, i[0] ^ i[1], 15'($random(seed)) | 15'h1000, 30'($random(seed)));
      // Core write, read back on the other port; only written halves compared
      for (int i = 0; i < 8; i++) begin
         a = 15'($random(seed)) | 15'h1000;
         d = 30'($random(seed));
         op(i % 2, 1'b1, a, d);
         msk = {{15{half[i % 2][1]}}, {15{half[i % 2][0]}}};
         op(1 - i % 2, 1'b0, a, 30'h0);
         chk("core_rdata", rd[1 - i % 2] & msk, d & msk);
      end
      // Simultaneous starts: two modules, one module, fast memory tie
      for (int i = 0; i < 3; i++) begin
         a = 15'($random(seed)) & 15'h0FFF | 15'h1000;
         b = i == 0 ? a | 15'h4000 : a + 15'h0001;
         if (i == 2) begin
            a = `SRD_RTC;
            b = `SRD_IDX_LO;
         end
         @(negedge sys_clk);
         post(0, 1'b0, a, 30'h0, 4'h0);
         post(1, 1'b1, b, 30'($random(seed)), 4'h0);
         finish(0, l);
         finish(1, l2);
         chk("tie_lat_a", l, lat_exp(a));
         chk("overlap_b", l2 == lat_exp(b), i == 0);
      end
      give_verdict();
   end

   // About 2000 cycles of traffic expected; ten times that means a hang
   initial begin
      #800us;
      error_cnt++;
      give_verdict();
   end
endmodule

bind srd_storage_region_decoder srd_region_chk #(.CTL_CYC(CTL_CYC), .BOOT_CYC(BOOT_CYC),
   .CORE_CYC(CORE_CYC)) u_chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .A_REQ(A_REQ),
   .A_WRITE(A_WRITE), .A_ADDR(A_ADDR), .A_ACK(A_ACK), .A_RDATA(A_RDATA),
   .A_REGION(A_REGION), .B_REQ(B_REQ), .B_ADDR(B_ADDR), .B_ACK(B_ACK));
